// >>> design/gwdr_gpio.sv
// GPIO port block: direction, data latches, pull-ups, Port A wake-up, drive levels and pin remapping
//
// Behaviour
// - Halt enters sleep; an enabled Port A wake event returns to run.
// - Falling edge on a wake-enabled Port A pin wakes the device.
// - Wake enable bits 7 and 4..0 are read/write, reset to zero.
// - Wake enable bits 6 and 5 ignore writes and read as zero.
// - Direction bit 1 makes a pin input, 0 a push-pull output.
// - Reading data of an input pin returns the pin level.
// - Reading data of an output pin returns the output latch.
// - All direction bits reset to one, so pins start as inputs.
// - All data latches reset high.
// - Single-bit set or clear reads the whole port, modifies, writes back.
// - Drive fields are two bits, 00 lowest to 11 highest, reset 00.
// - First drive register: B upper, B lower, A pins 7/4, A pins 3..0.
// - Second drive register: C halves low, D halves high where D exists.
// - Third drive register on largest variant: F, E halves; bits 7..6 zero.
// - Remap register exists and acts only on the smallest variant.
// - Remap bit 0 puts protection input 1 on C6 when 0, C2 when 1.
// - Input pins connect the weak pull-up when the pull-up bit is 1.
// - Inputs are read through a two-stage synchroniser, two clocks old; output latches hold until rewritten.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gwdr_defines.svh"

module gwdr_gpio #(
  parameter logic [1:0] VARIANT = `GWDR_VAR_LARGE
) (
  // Clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // APB slave
  input  wire gwdr_pkg::gwdr_apb_req_s apb_req,
  output var  gwdr_pkg::gwdr_apb_rsp_s apb_rsp,
  // Port pins
  input  wire gwdr_pkg::gwdr_ports_s  pin_in,
  output var  gwdr_pkg::gwdr_ports_s  pin_out,
  output var  gwdr_pkg::gwdr_ports_s  pin_oe,
  output var  gwdr_pkg::gwdr_ports_s  pin_pullup,
  // Drive strength and remap selects
  output var  gwdr_pkg::gwdr_drive_s  drive_level,
  output var  gwdr_pkg::gwdr_remap_s  remap_sel,
  // Power state
  output logic                        sleep_mode,
  output logic                        wake_event
);
  import gwdr_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    gwdr_ports_s   sync1;
    gwdr_ports_s   sync2;
    gwdr_ports_s   sync3;
    gwdr_ports_s   dir;
    gwdr_ports_s   data;
    gwdr_ports_s   pu;
    logic [7:0]    wake_en;
    logic [7:0]    drv_ab;
    logic [7:0]    drv_cd;
    logic [7:0]    drv_ef;
    logic [7:0]    remap;
    gwdr_pwr_e     pwr;
    logic          wake_pulse;
    gwdr_apb_rsp_s rsp;
    gwdr_ports_s   out;
    gwdr_ports_s   oe;
    gwdr_ports_s   pull;
  } gwdr_state_s;

  gwdr_state_s state_q;
  gwdr_state_s state_d;

  // --------------------------------------------------------------------------
  // Per-variant implemented bits
  // --------------------------------------------------------------------------
  function automatic gwdr_ports_s port_mask();
    gwdr_ports_s m;
    m.a = `GWDR_MASK_PA;
    m.b = 8'hFF;
    m.c = 8'hFF;
    m.d = (VARIANT != `GWDR_VAR_SMALL) ? 8'hFF : 8'h00;
    m.e = (VARIANT == `GWDR_VAR_LARGE) ? 8'hFF : 8'h00;
    m.f = (VARIANT == `GWDR_VAR_LARGE) ? `GWDR_MASK_PF : 8'h00;
    return m;
  endfunction

  localparam gwdr_ports_s PMASK = port_mask();
  localparam logic [7:0] DRV_CD_MASK = (VARIANT != `GWDR_VAR_SMALL) ? 8'hFF : `GWDR_MASK_DRV_C;
  localparam logic [7:0] DRV_EF_MASK = (VARIANT == `GWDR_VAR_LARGE) ? `GWDR_MASK_DRV_EF : 8'h00;
  localparam logic [7:0] REMAP_MASK  = (VARIANT == `GWDR_VAR_SMALL) ? `GWDR_MASK_REMAP : 8'h00;

  // Port index of a data, direction or pull-up offset: 3 bits of word index
  function automatic logic [7:0] sel_port(input gwdr_ports_s p, input logic [2:0] idx);
    case (idx)
      3'd0:    sel_port = p.a;
      3'd1:    sel_port = p.b;
      3'd2:    sel_port = p.c;
      3'd3:    sel_port = p.d;
      3'd4:    sel_port = p.e;
      3'd5:    sel_port = p.f;
      default: sel_port = 8'h00;
    endcase
  endfunction

  function automatic gwdr_ports_s put_port(input gwdr_ports_s p, input logic [2:0] idx, input logic [7:0] v);
    gwdr_ports_s r;
    r = p;
    case (idx)
      3'd0:    r.a = v;
      3'd1:    r.b = v;
      3'd2:    r.c = v;
      3'd3:    r.d = v;
      3'd4:    r.e = v;
      3'd5:    r.f = v;
      default: r = p;
    endcase
    return r & PMASK;
  endfunction

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic [11:0] ofs;
  logic [2:0]  pidx;
  logic [1:0]  grp;
  logic        hit;
  logic [7:0]  rd_byte;
  logic [7:0]  rmw;
  logic [7:0]  falls;
  gwdr_ports_s pin_view;

  always_comb begin
    state_d  = state_q;
    acc      = apb_req.psel && apb_req.penable;
    wr       = acc && apb_req.pwrite;
    ofs      = {apb_req.paddr[11:2], 2'b00};
    pidx     = ofs[4:2];
    grp      = ofs[6:5];
    hit      = 1'b0;
    rd_byte  = 8'h00;
    rmw      = 8'h00;
    falls    = 8'h00;
    // Input pins read the synchronised pin, output pins read the latch
    pin_view = (state_q.sync2 & state_q.dir) | (state_q.data & ~state_q.dir);

    state_d.sync1 = pin_in;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    state_d.rsp.pready  = 1'b0;
    state_d.rsp.pslverr = 1'b0;
    state_d.rsp.prdata  = 32'h0000_0000;

    // Register decode: data, direction, pull-up groups of six ports
    if ((grp == 2'd0) && (ofs[4:2] < 3'd6) && (ofs[11:7] == 5'd0)) begin
      hit     = 1'b1;
      rd_byte = sel_port(pin_view, pidx);
    end else if ((grp == 2'd1) && (ofs[4:2] < 3'd6) && (ofs[11:7] == 5'd0)) begin
      hit     = 1'b1;
      rd_byte = sel_port(state_q.dir, pidx);
    end else if ((grp == 2'd2) && (ofs[4:2] < 3'd6) && (ofs[11:7] == 5'd0)) begin
      hit     = 1'b1;
      rd_byte = sel_port(state_q.pu, pidx);
    end else if (ofs == `GWDR_OFS_WAKE) begin
      hit     = 1'b1;
      rd_byte = state_q.wake_en;
    end else if (ofs == `GWDR_OFS_DRV_AB) begin
      hit     = 1'b1;
      rd_byte = state_q.drv_ab;
    end else if (ofs == `GWDR_OFS_DRV_CD) begin
      hit     = 1'b1;
      rd_byte = state_q.drv_cd;
    end else if (ofs == `GWDR_OFS_DRV_EF) begin
      hit     = 1'b1;
      rd_byte = state_q.drv_ef;
    end else if (ofs == `GWDR_OFS_REMAP) begin
      hit     = 1'b1;
      rd_byte = state_q.remap;
    end else if (ofs == `GWDR_OFS_PWR) begin
      hit     = 1'b1;
      rd_byte = {7'h00, state_q.pwr == GWDR_SLEEP};
    end else if ((ofs >= `GWDR_OFS_BSR) && (ofs < `GWDR_OFS_BSR + 12'h018)) begin
      hit     = 1'b1;
      rd_byte = 8'h00;
    end

    if (acc && !state_q.rsp.pready) begin
      state_d.rsp.pready  = 1'b1;
      state_d.rsp.pslverr = !hit;
      state_d.rsp.prdata  = {24'h00_0000, apb_req.pwrite ? 8'h00 : rd_byte};
      if (wr && hit) begin
        if (grp == 2'd0 && ofs < `GWDR_OFS_DIR_A) begin
          state_d.data = put_port(state_q.data, pidx, apb_req.pwdata[7:0]);
        end else if (grp == 2'd1) begin
          state_d.dir = put_port(state_q.dir, pidx, apb_req.pwdata[7:0]);
        end else if (grp == 2'd2) begin
          state_d.pu = put_port(state_q.pu, pidx, apb_req.pwdata[7:0]);
        end else if (ofs == `GWDR_OFS_WAKE) begin
          state_d.wake_en = apb_req.pwdata[7:0] & `GWDR_MASK_PA;
        end else if (ofs == `GWDR_OFS_DRV_AB) begin
          state_d.drv_ab = apb_req.pwdata[7:0];
        end else if (ofs == `GWDR_OFS_DRV_CD) begin
          state_d.drv_cd = apb_req.pwdata[7:0] & DRV_CD_MASK;
        end else if (ofs == `GWDR_OFS_DRV_EF) begin
          state_d.drv_ef = apb_req.pwdata[7:0] & DRV_EF_MASK;
        end else if (ofs == `GWDR_OFS_REMAP) begin
          state_d.remap = apb_req.pwdata[7:0] & REMAP_MASK;
        end else if (ofs == `GWDR_OFS_PWR) begin
          if (apb_req.pwdata[`GWDR_BIT_PWR_HALT]) begin
            state_d.pwr = GWDR_SLEEP;
          end
        end else begin
          // Bit set/clear on a data latch: whole port read, bit changed, byte written back
          rmw = sel_port(pin_view, 3'((ofs - `GWDR_OFS_BSR) >> 2));
          rmw = (rmw | apb_req.pwdata[`GWDR_BSR_SET +: 8]) & ~apb_req.pwdata[7:0];
          state_d.data = put_port(state_q.data, 3'((ofs - `GWDR_OFS_BSR) >> 2), rmw);
        end
      end
    end

    // Falling edge on synchronised Port A, qualified by its wake enable
    falls = state_q.sync3.a & ~state_q.sync2.a & state_q.wake_en;
    state_d.wake_pulse = 1'b0;
    case (state_q.pwr)
      GWDR_RUN: begin
        state_d.wake_pulse = 1'b0;
      end
      GWDR_SLEEP: begin
        if (falls != 8'h00) begin
          state_d.pwr        = GWDR_RUN;
          state_d.wake_pulse = 1'b1;
        end
      end
      default: begin
        state_d.pwr = GWDR_RUN;
      end
    endcase

    // Registered pin drive; pull-up only on input pins
    state_d.out  = state_d.data & PMASK;
    state_d.oe   = ~state_d.dir & PMASK;
    state_d.pull = state_d.pu & state_d.dir & PMASK;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q            <= '0;
      state_q.dir        <= {6{`GWDR_RST_DIR}} & PMASK;
      state_q.data       <= {6{`GWDR_RST_DATA}} & PMASK;
      state_q.pu         <= {6{`GWDR_RST_PU}};
      state_q.wake_en    <= `GWDR_RST_WAKE;
      state_q.drv_ab     <= `GWDR_RST_DRV;
      state_q.drv_cd     <= `GWDR_RST_DRV;
      state_q.drv_ef     <= `GWDR_RST_DRV;
      state_q.remap      <= `GWDR_RST_REMAP;
      state_q.pwr        <= GWDR_RUN;
      state_q.out        <= {6{`GWDR_RST_DATA}} & PMASK;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs, all from flip-flops
  // --------------------------------------------------------------------------
  assign apb_rsp    = state_q.rsp;
  assign pin_out    = state_q.out;
  assign pin_oe     = state_q.oe;
  assign pin_pullup = state_q.pull;
  assign sleep_mode = (state_q.pwr == GWDR_SLEEP);
  assign wake_event = state_q.wake_pulse;
  assign remap_sel  = state_q.remap[3:0];
  // Field split of the three drive registers
  assign drive_level.portb_upper_drive = state_q.drv_ab[7:6];
  assign drive_level.portb_lower_drive = state_q.drv_ab[5:4];
  assign drive_level.porta_upper_drive = state_q.drv_ab[3:2];
  assign drive_level.porta_lower_drive = state_q.drv_ab[1:0];
  assign drive_level.portd_upper_drive = state_q.drv_cd[7:6];
  assign drive_level.portd_lower_drive = state_q.drv_cd[5:4];
  assign drive_level.portc_upper_drive = state_q.drv_cd[3:2];
  assign drive_level.portc_lower_drive = state_q.drv_cd[1:0];
  assign drive_level.portf_drive       = state_q.drv_ef[5:4];
  assign drive_level.porte_upper_drive = state_q.drv_ef[3:2];
  assign drive_level.porte_lower_drive = state_q.drv_ef[1:0];
endmodule
`default_nettype wire

// >>> include/gwdr_defines.svh
// Register offsets, field positions, reset values and variant codes for the GPIO wake/drive/remap block
`ifndef GWDR_DEFINES_SVH
`define GWDR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets (APB, one word each)
// ----------------------------------------------------------------------------
`define GWDR_OFS_DATA_A    12'h000
`define GWDR_OFS_DATA_B    12'h004
`define GWDR_OFS_DATA_C    12'h008
`define GWDR_OFS_DATA_D    12'h00C
`define GWDR_OFS_DATA_E    12'h010
`define GWDR_OFS_DATA_F    12'h014
`define GWDR_OFS_DIR_A     12'h020
`define GWDR_OFS_PU_A      12'h040
`define GWDR_OFS_WAKE      12'h060
`define GWDR_OFS_DRV_AB    12'h064
`define GWDR_OFS_DRV_CD    12'h068
`define GWDR_OFS_DRV_EF    12'h06C
`define GWDR_OFS_REMAP     12'h070
`define GWDR_OFS_PWR       12'h074
`define GWDR_OFS_BSR       12'h078

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define GWDR_RST_DIR       8'hFF
`define GWDR_RST_DATA      8'hFF
`define GWDR_RST_PU        8'h00
`define GWDR_RST_WAKE      8'h00
`define GWDR_RST_DRV       8'h00
`define GWDR_RST_REMAP     8'h00
`define GWDR_MASK_PA       8'h9F
`define GWDR_MASK_PF       8'h0F
`define GWDR_MASK_DRV_C    8'h0F
`define GWDR_MASK_DRV_EF   8'h3F
`define GWDR_MASK_REMAP    8'h0F

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GWDR_BIT_PWR_HALT  0
`define GWDR_BIT_REMAP_IN1 0
`define GWDR_BSR_SET       8

// ----------------------------------------------------------------------------
// Variant codes
// ----------------------------------------------------------------------------
`define GWDR_VAR_SMALL     2'd0
`define GWDR_VAR_MID       2'd1
`define GWDR_VAR_LARGE     2'd2

`endif

// >>> include/gwdr_pkg.sv
// Types of the GPIO wake/drive/remap block
package gwdr_pkg;

  typedef enum logic [1:0] {
    GWDR_RUN   = 2'b01,
    GWDR_SLEEP = 2'b10
  } gwdr_pwr_e;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] f;
  } gwdr_ports_s;

  typedef struct packed {
    logic [1:0] porta_upper_drive;
    logic [1:0] porta_lower_drive;
    logic [1:0] portb_upper_drive;
    logic [1:0] portb_lower_drive;
    logic [1:0] portc_upper_drive;
    logic [1:0] portc_lower_drive;
    logic [1:0] portd_upper_drive;
    logic [1:0] portd_lower_drive;
    logic [1:0] porte_upper_drive;
    logic [1:0] porte_lower_drive;
    logic [1:0] portf_drive;
  } gwdr_drive_s;

  typedef struct packed {
    logic timer_inv_out_remap;
    logic timer_out_remap;
    logic protect_in2_remap;
    logic protect_in1_remap;
  } gwdr_remap_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } gwdr_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gwdr_apb_rsp_s;

endpackage

// >>> verif/gwdr_properties.sv
// Port-level checker for the GPIO wake/drive/remap block
`timescale 1ns/1ps
`default_nettype none
`include "gwdr_defines.svh"
module gwdr_properties #(
  parameter logic [1:0] VARIANT = `GWDR_VAR_LARGE
) (
  // Clock, reset, enable
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    clk_en,
  // APB
  input wire gwdr_pkg::gwdr_apb_req_s apb_req,
  input wire gwdr_pkg::gwdr_apb_rsp_s apb_rsp,
  // Pins
  input wire gwdr_pkg::gwdr_ports_s   pin_in,
  input wire gwdr_pkg::gwdr_ports_s   pin_out,
  input wire gwdr_pkg::gwdr_ports_s   pin_oe,
  input wire gwdr_pkg::gwdr_ports_s   pin_pullup,
  // Selects and power
  input wire gwdr_pkg::gwdr_drive_s   drive_level,
  input wire gwdr_pkg::gwdr_remap_s   remap_sel,
  input wire logic                    sleep_mode,
  input wire logic                    wake_event
);
  import gwdr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        wr_done;
  logic        rd_done;
  logic [11:0] ad;
  logic [31:0] wd;
  assign wr_done = apb_rsp.pready && apb_req.pwrite;
  assign rd_done = apb_rsp.pready && !apb_req.pwrite;
  assign ad = apb_req.paddr;
  assign wd = apb_req.pwdata;
  sequence s_setup;
    apb_req.psel && !apb_req.penable && clk_en;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && clk_en;
  endsequence
  chk_ready_timing: assert property (s_setup ##1 s_access |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("pready not a pulse one cycle into access");
  chk_reset_dir: assert property ($rose(resetn) |-> pin_oe == '0 && pin_pullup == '0 && !sleep_mode)
    else $error("pins not inputs after reset");
  chk_reset_latch: assert property ($rose(resetn) |-> pin_out.b == 8'hFF && pin_out.c == 8'hFF)
    else $error("data latches not high after reset");
  chk_pull_input: assert property ((pin_pullup & pin_oe) == '0)
    else $error("pull-up on a driven pin");
  chk_dir_write: assert property (wr_done && ad == `GWDR_OFS_DIR_A |-> pin_oe.a == (~wd[7:0] & 8'h9F))
    else $error("direction write not on enables");
  chk_drive_ab: assert property (wr_done && ad == `GWDR_OFS_DRV_AB |-> {drive_level.portb_upper_drive,
    drive_level.portb_lower_drive, drive_level.porta_upper_drive, drive_level.porta_lower_drive} == wd[7:0])
    else $error("drive fields mismatch");
  chk_remap_var: assert property (wr_done && ad == `GWDR_OFS_REMAP |->
    remap_sel == ((VARIANT == `GWDR_VAR_SMALL) ? wd[3:0] : 4'h0))
    else $error("remap select wrong for variant");
  chk_halt_sleep: assert property (wr_done && ad == `GWDR_OFS_PWR && wd[0] |-> sleep_mode)
    else $error("halt did not enter sleep");
  chk_wake_ends: assert property (wake_event |-> $past(sleep_mode) && !sleep_mode ##1 !wake_event)
    else $error("wake pulse without leaving sleep");
  chk_wake_gap: assert property (rd_done && ad == `GWDR_OFS_WAKE |-> apb_rsp.prdata[6:5] == 2'b00)
    else $error("wake bits 6..5 not zero");
endmodule
bind gwdr_gpio gwdr_properties #(.VARIANT(VARIANT)) u_props (.clk(clk), .resetn(resetn), .clk_en(clk_en),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup(pin_pullup), .drive_level(drive_level), .remap_sel(remap_sel), .sleep_mode(sleep_mode),
  .wake_event(wake_event));
`default_nettype wire

// >>> verif/gwdr_switch_model.sv
// Switches and loads on the port pins
`timescale 1ns/1ps
`default_nettype none
module gwdr_switch_model (
  // Clock
  input  wire logic                 clk,
  // Block pin side
  input  wire gwdr_pkg::gwdr_ports_s pin_out,
  input  wire gwdr_pkg::gwdr_ports_s pin_oe,
  input  wire gwdr_pkg::gwdr_ports_s pin_pullup,
  // Switch level and closed flags
  input  wire gwdr_pkg::gwdr_ports_s sw_level,
  input  wire gwdr_pkg::gwdr_ports_s sw_on,
  output var  gwdr_pkg::gwdr_ports_s pin_in
);
  import gwdr_pkg::*;
  logic [47:0] float_q = '0;
  // Open lines wander so a missing pull-up never reads as a clean level
  always_ff @(posedge clk) float_q <= ~float_q;
  always_comb pin_in = gwdr_ports_s'((pin_oe & pin_out) | (~pin_oe & sw_on & sw_level)
                     | (~pin_oe & ~sw_on & (pin_pullup | float_q)));
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the GPIO wake/drive/remap block
`timescale 1ns/1ps
`default_nettype none
`include "gwdr_defines.svh"
module testbench;
  import gwdr_pkg::*;
  logic          clk = 1'b0;
  logic          resetn = 1'b0;
  logic          clk_en = 1'b1;
  gwdr_apb_req_s req = '0;
  gwdr_apb_rsp_s rsp;
  gwdr_ports_s   pin_in, pin_out, pin_oe, pin_pullup;
  gwdr_ports_s   sw_level = {8'hFF, 8'h3C, 8'hA0, 24'h0};
  gwdr_ports_s   sw_on = '1;
  gwdr_drive_s   drive_level;
  gwdr_remap_s   remap_sel;
  logic          sleep_mode, wake_event;
  int            num_errors = 0;
  int            n_checks = 0;
  always #4 clk = ~clk;
  gwdr_gpio #(.VARIANT(`GWDR_VAR_SMALL)) DUT (.clk(clk), .resetn(resetn), .clk_en(clk_en), .apb_req(req),
    .apb_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .drive_level(drive_level), .remap_sel(remap_sel), .sleep_mode(sleep_mode), .wake_event(wake_event));
  gwdr_switch_model u_sw (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .sw_level(sw_level), .sw_on(sw_on), .pin_in(pin_in));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    // Look mid-cycle: what stands now is what the next rising edge samples
    @(negedge clk);
    while (rsp.pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    @(posedge clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // Outputs land on the answer edge; let them settle before looking
    @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad, wd, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h0, r, e);
    chk(r, exp);
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(`GWDR_OFS_DIR_A, 32'h9F);
    rd_chk(`GWDR_OFS_DIR_A + 12'h008, 32'hFF);
    rd_chk(`GWDR_OFS_WAKE, 32'h0);
    rd_chk(`GWDR_OFS_DRV_AB, 32'h0);
    rd_chk(`GWDR_OFS_REMAP, 32'h0);
    rd_chk(`GWDR_OFS_DATA_B, 32'h3C);
    wr(`GWDR_OFS_DIR_A + 12'h004, 32'h0);
    chk(32'(pin_out.b), 32'hFF);
    chk(32'(pin_oe.b), 32'hFF);
    $display("test reset done");
  endtask
  task automatic t_io();
    wr(`GWDR_OFS_DATA_B, 32'hA5);
    wr(`GWDR_OFS_DIR_A + 12'h004, 32'h0F);
    chk(32'(pin_oe.b), 32'hF0);
    wr(`GWDR_OFS_DIR_A, 32'h9F);
    chk(32'(pin_oe.a), 32'h00);
    wr(`GWDR_OFS_PU_A + 12'h004, 32'hFF);
    chk(32'(pin_pullup.b), 32'h0F);
    @(posedge clk);
    sw_on.b <= 8'h00;
    repeat (4) @(posedge clk);
    rd_chk(`GWDR_OFS_DATA_B, 32'hAF);
    $display("test io done");
  endtask
  task automatic t_bitset();
    wr(`GWDR_OFS_DATA_C, 32'h55);
    wr(`GWDR_OFS_DIR_A + 12'h008, 32'hF0);
    wr(`GWDR_OFS_BSR + 12'h008, 32'h0204);
    chk(32'(pin_out.c), 32'hA3);
    wr(`GWDR_OFS_DIR_A + 12'h008, 32'h00);
    rd_chk(`GWDR_OFS_DATA_C, 32'hA3);
    $display("test bitset done");
  endtask
  task automatic t_drive();
    logic [31:0] r;
    logic        e;
    wr(`GWDR_OFS_DRV_AB, 32'hE4);
    chk(32'({drive_level.portb_upper_drive, drive_level.portb_lower_drive, drive_level.porta_upper_drive,
             drive_level.porta_lower_drive}), 32'hE4);
    wr(`GWDR_OFS_DRV_CD, 32'hFF);
    rd_chk(`GWDR_OFS_DRV_CD, 32'h0F);
    wr(`GWDR_OFS_REMAP, 32'hFF);
    chk(32'(remap_sel), 32'h0F);
    apb(1'b0, 12'hFF0, 32'h0, r, e);
    chk(32'(e), 32'h1);
    $display("test drive done");
  endtask
  task automatic t_wake();
    int n;
    wr(`GWDR_OFS_WAKE, 32'hFF);
    rd_chk(`GWDR_OFS_WAKE, 32'h9F);
    wr(`GWDR_OFS_PWR, 32'h1);
    chk(32'(sleep_mode), 32'h1);
    @(posedge clk);
    sw_level.a <= 8'hBF;
    repeat (8) @(posedge clk);
    chk(32'(sleep_mode), 32'h1);
    sw_level.a <= 8'h3F;
    n = 0;
    while (wake_event !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n < 10), 32'h1);
    @(negedge clk);
    chk(32'(sleep_mode), 32'h0);
    wr(`GWDR_OFS_WAKE, 32'h01);
    @(posedge clk);
    sw_level.a <= 8'hFF;
    wr(`GWDR_OFS_PWR, 32'h1);
    @(posedge clk);
    sw_level.a <= 8'hFD;
    repeat (8) @(posedge clk);
    chk(32'(sleep_mode), 32'h1);
    $display("test wake done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_io();
    t_bitset();
    t_drive();
    t_wake();
    give_verdict();
  end
endmodule
`default_nettype wire
